// File: core/eanp_lpi_ctrl.sv
`timescale 1ns/1ps
`include "eanp_regs.svh"
module eanp_lpi_ctrl
  import eanp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  eanp_lpi_if.ctrl lk
);
  localparam logic [14:0] UNIT_CYC = 15'(`EANP_RECOV_UNIT_CYC);

  // ----------------------------------------------------------------
  // withdrawal causes
  // ----------------------------------------------------------------
  logic [EANP_NPORT-1:0] over;
  genvar gi;
  generate
    for (gi = 0; gi < EANP_NPORT; gi++) begin : g_port
      // usage counts 512-byte units, same unit as the limit
      assign over[gi] = lk.usage[gi] > {1'b0, lk.buf_limit}; // [R8]
    end
  endgenerate

  wire traffic_stop = lk.traffic_en & lk.traffic; // [R7]
  wire buf_stop = |over;
  wire withdraw = traffic_stop | buf_stop;

  // ----------------------------------------------------------------
  // lpi state and recovery wait
  // ----------------------------------------------------------------
  eanp_lpi_state_e state, next_state;
  logic [14:0] count, next_count;
  wire [14:0] wait_cyc = 15'(lk.recovery * UNIT_CYC); // [R5]
  wire leave_lpi = ~lk.lpi_req | lk.fiber | withdraw;

  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      LS_IDLE: begin
        // fiber ports never enter low-power idle
        if (lk.lpi_req & ~lk.fiber & ~withdraw) begin // [R14] [R7]
          next_state = LS_LPI;
        end
      end
      LS_LPI: begin
        if (leave_lpi) begin
          next_count = wait_cyc;
          next_state = (wait_cyc == 15'h0000) ? LS_IDLE : LS_RECOVER;
        end
      end
      LS_RECOVER: begin
        next_count = count - 15'h0001; // [R5]
        if (count == 15'h0001) begin
          next_state = LS_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= LS_IDLE;
      count <= 15'h0000;
      lk.lpi_active <= 1'b0;
      lk.tx_hold <= 1'b0;
      lk.terminate <= '0;
      lk.buf_evt <= 1'b0;
      lk.traffic_evt <= 1'b0;
    end else begin
      state <= next_state;
      count <= next_count;
      lk.lpi_active <= (next_state == LS_LPI);
      lk.tx_hold <= (next_state == LS_RECOVER); // [R5]
      lk.terminate <= (state == LS_LPI) ? over : '0; // [R8]
      lk.buf_evt <= (state == LS_LPI) & buf_stop;
      lk.traffic_evt <= (state == LS_LPI) & traffic_stop;
    end
  end
endmodule

// File: core/eanp_lpi_if.sv
`timescale 1ns/1ps
interface eanp_lpi_if;
  import eanp_pkg::*;
  logic [7:0] recovery;
  logic traffic_en;
  logic [5:0] buf_limit;
  logic fiber;
  logic lpi_req;
  logic traffic;
  eanp_usage_t usage [EANP_NPORT];
  logic lpi_active;
  logic tx_hold;
  logic [EANP_NPORT-1:0] terminate;
  logic buf_evt;
  logic traffic_evt;
  modport regs (output recovery, traffic_en, buf_limit, fiber, lpi_req, traffic, usage,
                input lpi_active, tx_hold, terminate, buf_evt, traffic_evt);
  modport ctrl (input recovery, traffic_en, buf_limit, fiber, lpi_req, traffic, usage,
                output lpi_active, tx_hold, terminate, buf_evt, traffic_evt);
endinterface

// File: core/eanp_pkg.sv
package eanp_pkg;
  localparam int EANP_NPORT = 3;
  typedef enum logic [1:0] {
    LS_IDLE,
    LS_LPI,
    LS_RECOVER
  } eanp_lpi_state_e;
  typedef logic [6:0] eanp_usage_t;
endpackage

// File: core/eanp_regs.svh
`ifndef EANP_REGS_SVH
`define EANP_REGS_SVH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define EANP_IDX_P1_STATUS 10'h0e4
`define EANP_IDX_P1_RECOVERY 10'h0e6
`define EANP_IDX_BUF_LPI_CTRL 10'h0e7
`define EANP_IDX_P2_NP_TX 10'h0e8
`define EANP_IDX_P2_NP_STAGE 10'h0f0
`define EANP_IDX_IRQ_STATUS 10'h0f1
`define EANP_IDX_IRQ_MASK 10'h0f2

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define EANP_ST_NP_ABLE 2
`define EANP_ST_PAGE_RX 1
`define EANP_ST_LP_AN_ABLE 0
`define EANP_BL_TRAFFIC_EN 7
`define EANP_NP_MORE 15
`define EANP_NP_MSG 13
`define EANP_NP_COMPLY 12
`define EANP_NP_TOGGLE 11
`define EANP_IRQ_PAGE 0
`define EANP_IRQ_BUF 1
`define EANP_IRQ_TRAFFIC 2

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define EANP_RST_RECOVERY 8'h27
`define EANP_RST_BUF_LIMIT 6'h08
`define EANP_RST_NP_STAGE 16'h2001
`define EANP_RST_IRQ_MASK 3'h0

// ----------------------------------------------------------------
// timing: one recovery count is 640 ns, clock period 5 ns
// ----------------------------------------------------------------
`define EANP_RECOV_UNIT_PS 640000
`define EANP_CLK_PERIOD_PS 5000
`define EANP_RECOV_UNIT_CYC ((`EANP_RECOV_UNIT_PS + `EANP_CLK_PERIOD_PS - 1) / `EANP_CLK_PERIOD_PS)

`endif

// File: core/eanp_regs_top.sv
// Functional notes
// R1: status bit 2 reads 1 when the local port can exchange next pages, read-only.
// R2: status bit 1 latches high when a new page arrives from the partner and holds until cleared.
// R3: reading the status register clears the page flag unless a page arrives in that same cycle.
// R4: status bit 0 shows, read-only, whether the partner can auto-negotiate.
// R5: the 8-bit recovery field, reset 0x27, holds transmit off for its value times 640 ns after low-power idle.
// R6: software should program the recovery field with the larger of the local and remote recovery times.
// R7: with control bit 7 set, detected input traffic withdraws a pending low-power request; cleared, it does not.
// R8: control bits 5..0, reset 0x08, are a per-port buffer limit in 512-byte units that ends idle when exceeded.
// R9: codeword bit 15 is 1 when more next pages follow and 0 on the last page.
// R10: codeword bit 13 marks a message page (1) or unformatted page (0) and resets to 1.
// R11: codeword bit 12 is 1 when the device can comply with the received message.
// R12: codeword bit 11 toggles per exchanged page and starts as the inverse of base page bit 11.
// R13: codeword bits 10..0 carry the message or unformatted code, reset 0x001.
// R14: low-power idle never operates on a port set to fiber mode.
//
// Register access over AHB-Lite was left to the implementer.
`timescale 1ns/1ps
`include "eanp_regs.svh"
module eanp_regs_top
  import eanp_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic local_np_able,
  input wire logic partner_an_able,
  input wire logic page_rx,
  input wire logic fiber_mode_pin,
  input wire logic lpi_req,
  input wire logic input_traffic,
  input wire logic [EANP_NPORT*7-1:0] buf_usage,
  input wire logic np_base_load,
  input wire logic np_base_toggle,
  input wire logic np_page_sent,
  output logic lpi_active,
  output logic tx_hold,
  output logic [EANP_NPORT-1:0] lpi_terminate,
  output logic [15:0] np_codeword,
  output logic irq
);
  // ----------------------------------------------------------------
  // fiber strap synchroniser
  // ----------------------------------------------------------------
  logic fib_s1, fib_s2, fib_s3, fiber;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fib_s1 <= 1'b0;
      fib_s2 <= 1'b0;
      fib_s3 <= 1'b0;
      fiber <= 1'b0;
    end else begin
      fib_s1 <= fiber_mode_pin;
      fib_s2 <= fib_s1;
      fib_s3 <= fib_s2;
      // a change is taken only once two stages agree
      if (fib_s2 == fib_s3) begin
        fiber <= fib_s3;
      end
    end
  end

  // ----------------------------------------------------------------
  // lpi controller
  // ----------------------------------------------------------------
  eanp_lpi_if lk ();
  logic [7:0] recovery;
  logic traffic_en;
  logic [5:0] buf_limit;

  assign lk.recovery = recovery;
  assign lk.traffic_en = traffic_en;
  assign lk.buf_limit = buf_limit;
  assign lk.fiber = fiber;
  assign lk.lpi_req = lpi_req;
  assign lk.traffic = input_traffic;
  genvar gi;
  generate
    for (gi = 0; gi < EANP_NPORT; gi++) begin : g_use
      assign lk.usage[gi] = buf_usage[gi*7 +: 7];
    end
  endgenerate

  eanp_lpi_ctrl u_ctrl (
    .sys_clk(sys_clk),
    .rst(rst),
    .lk(lk)
  );

  assign lpi_active = lk.lpi_active;
  assign tx_hold = lk.tx_hold;
  assign lpi_terminate = lk.terminate;

  // ----------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------
  wire take = hsel & htrans[1] & hready;
  wire take_rd = take & ~hwrite;
  wire take_wr = take & hwrite;
  logic wr_pend, rd_pend;
  logic [9:0] wr_idx, rd_idx;

  wire hit_status_rd = rd_pend & (rd_idx == `EANP_IDX_P1_STATUS);
  wire hit_irq_rd = rd_pend & (rd_idx == `EANP_IDX_IRQ_STATUS);
  wire wr_recovery = wr_pend & (wr_idx == `EANP_IDX_P1_RECOVERY);
  wire wr_bufctl = wr_pend & (wr_idx == `EANP_IDX_BUF_LPI_CTRL);
  wire wr_stage = wr_pend & (wr_idx == `EANP_IDX_P2_NP_STAGE);
  wire wr_mask = wr_pend & (wr_idx == `EANP_IDX_IRQ_MASK);
  wire upper_zero = (haddr[31:12] == 20'h00000);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wr_pend <= 1'b0;
      rd_pend <= 1'b0;
      wr_idx <= 10'h000;
      rd_idx <= 10'h000;
    end else begin
      wr_pend <= take_wr;
      rd_pend <= take_rd;
      // out-of-window addresses decode to an unused index
      if (take) begin
        wr_idx <= upper_zero ? haddr[11:2] : 10'h3ff;
        rd_idx <= upper_zero ? haddr[11:2] : 10'h3ff;
      end
    end
  end

  // ----------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------
  logic [15:0] np_stage;
  logic [2:0] irq_mask;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      recovery <= `EANP_RST_RECOVERY; // [R5]
      traffic_en <= 1'b0;
      buf_limit <= `EANP_RST_BUF_LIMIT; // [R8]
      np_stage <= `EANP_RST_NP_STAGE; // [R10] [R13]
      irq_mask <= `EANP_RST_IRQ_MASK;
    end else begin
      if (wr_recovery) begin
        recovery <= hwdata[7:0];
      end
      if (wr_bufctl) begin
        traffic_en <= hwdata[`EANP_BL_TRAFFIC_EN]; // [R7]
        buf_limit <= hwdata[5:0]; // [R8]
      end
      if (wr_stage) begin
        np_stage <= hwdata[15:0];
      end
      if (wr_mask) begin
        irq_mask <= hwdata[2:0];
      end
    end
  end

  // ----------------------------------------------------------------
  // next-page toggle and codeword
  // ----------------------------------------------------------------
  logic np_toggle;
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      np_toggle <= 1'b0;
    end else if (np_base_load) begin
      np_toggle <= ~np_base_toggle; // [R12]
    end else if (np_page_sent) begin
      np_toggle <= ~np_toggle; // [R12]
    end
  end

  wire [15:0] np_word = {np_stage[`EANP_NP_MORE], 1'b0, np_stage[`EANP_NP_MSG],
                         np_stage[`EANP_NP_COMPLY], np_toggle, np_stage[10:0]}; // [R9] [R10] [R11] [R13]

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      np_codeword <= 16'h0000;
    end else begin
      np_codeword <= np_word;
    end
  end

  // ----------------------------------------------------------------
  // page flag and sticky events
  // ----------------------------------------------------------------
  logic page_flag;
  logic [2:0] irq_status;
  logic rd_wait;
  wire rd_now = rd_pend & ~rd_wait;
  wire [2:0] irq_set = {lk.traffic_evt, lk.buf_evt, page_rx};

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      page_flag <= 1'b0;
    end else if (page_rx) begin
      page_flag <= 1'b1; // [R2]
    end else if (hit_status_rd & rd_now) begin
      page_flag <= 1'b0; // [R3]
    end
  end

  // set wins over the read clear
  wire [2:0] next_irq_status = irq_set | ((hit_irq_rd & rd_now) ? 3'h0 : irq_status);

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_status <= 3'h0;
      irq <= 1'b0;
    end else begin
      irq_status <= next_irq_status;
      irq <= |(next_irq_status & irq_mask);
    end
  end

  // ----------------------------------------------------------------
  // read mux and answer
  // ----------------------------------------------------------------
  wire [15:0] status_word = {13'h0000, local_np_able, page_flag, partner_an_able}; // [R1] [R2] [R4]
  logic [31:0] rd_mux;
  always_comb begin
    unique case (rd_idx)
      `EANP_IDX_P1_STATUS: rd_mux = {16'h0000, status_word};
      `EANP_IDX_P1_RECOVERY: rd_mux = {24'h000000, recovery};
      `EANP_IDX_BUF_LPI_CTRL: rd_mux = {24'h000000, traffic_en, 1'b0, buf_limit};
      `EANP_IDX_P2_NP_TX: rd_mux = {16'h0000, np_word};
      `EANP_IDX_P2_NP_STAGE: rd_mux = {16'h0000, np_stage};
      `EANP_IDX_IRQ_STATUS: rd_mux = {29'h00000000, irq_status};
      `EANP_IDX_IRQ_MASK: rd_mux = {29'h00000000, irq_mask};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // reads take one wait state so the data reflect any write just before
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      rd_wait <= 1'b0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h00000000;
    end else begin
      rd_wait <= rd_now;
      hreadyout <= ~take_rd;
      hresp <= 1'b0;
      if (rd_now) begin
        hrdata <= rd_mux;
      end
    end
  end
endmodule

// File: verification/eanp_regs_top_properties.sv
`timescale 1ns/1ps
module eanp_regs_chk (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic fiber_mode_pin,
  input wire logic lpi_req,
  input wire logic np_base_load,
  input wire logic np_base_toggle,
  input wire logic np_page_sent,
  input wire logic lpi_active,
  input wire logic tx_hold,
  input wire logic [15:0] np_codeword
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  wire logic take = hsel && htrans[1] && hready;
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  property p_resp_okay;
    hresp == 1'b0;
  endproperty
  a_resp_okay: assert property (p_resp_okay) else $error("error response seen");
  property p_rd_wait;
    take && !hwrite |=> !hreadyout ##1 hreadyout;
  endproperty
  a_rd_wait: assert property (p_rd_wait) else $error("read wait state wrong");
  property p_wr_zero;
    take && hwrite |=> hreadyout;
  endproperty
  a_wr_zero: assert property (p_wr_zero) else $error("write stalled");
  property p_np_reset;
    $fell(rst) |=> np_codeword == 16'h2001;
  endproperty
  a_np_reset: assert property (p_np_reset) else $error("codeword reset wrong");
  property p_np_rsvd;
    np_codeword[14] == 1'b0;
  endproperty
  a_np_rsvd: assert property (p_np_rsvd) else $error("codeword bit 14 set");
  property p_np_first;
    np_base_load |=> ##1 np_codeword[11] == !$past(np_base_toggle, 2);
  endproperty
  a_np_first: assert property (p_np_first) else $error("first toggle wrong");
  property p_np_toggle;
    np_page_sent && !np_base_load |=> ##1 np_codeword[11] != $past(np_codeword[11]);
  endproperty
  a_np_toggle: assert property (p_np_toggle) else $error("toggle did not invert");
  property p_hold_start;
    $rose(tx_hold) |-> $fell(lpi_active);
  endproperty
  a_hold_start: assert property (p_hold_start) else $error("hold without idle exit");
  property p_hold_excl;
    !(tx_hold && lpi_active);
  endproperty
  a_hold_excl: assert property (p_hold_excl) else $error("idle during hold");
  property p_fiber;
    fiber_mode_pin [*7] |-> !lpi_active;
  endproperty
  a_fiber: assert property (p_fiber) else $error("idle in fiber mode");
  property p_req_drop;
    lpi_active && !lpi_req |=> !lpi_active;
  endproperty
  a_req_drop: assert property (p_req_drop) else $error("idle kept without request");
endmodule

bind eanp_regs_top eanp_regs_chk eanp_regs_chk_i (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .fiber_mode_pin(fiber_mode_pin), .lpi_req(lpi_req),
  .np_base_load(np_base_load), .np_base_toggle(np_base_toggle), .np_page_sent(np_page_sent),
  .lpi_active(lpi_active), .tx_hold(tx_hold), .np_codeword(np_codeword));

// File: verification/eanp_regs_top_tb_top.sv
`timescale 1ns/1ps
`include "eanp_regs.svh"
module eanp_regs_top_tb_top;
  import eanp_pkg::*;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout, hresp, lpi_active, tx_hold, irq;
  logic [31:0] hrdata;
  logic [2:0] lpi_terminate, t;
  logic [15:0] np_codeword, e;
  logic np_able = 1'b0;
  logic an_able = 1'b0;
  logic page_rx = 1'b0;
  logic fiber = 1'b0;
  logic lpi_req = 1'b0;
  logic traffic = 1'b0;
  logic [EANP_NPORT*7-1:0] usage = '0;
  logic base_load = 1'b0;
  logic base_tog = 1'b0;
  logic page_sent = 1'b0;
  int err_total = 0;
  int total_checks = 0;
  int n;

  eanp_regs_top eanp_regs_top_i (
    .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .local_np_able(np_able), .partner_an_able(an_able), .page_rx(page_rx),
    .fiber_mode_pin(fiber), .lpi_req(lpi_req), .input_traffic(traffic), .buf_usage(usage),
    .np_base_load(base_load), .np_base_toggle(base_tog), .np_page_sent(page_sent),
    .lpi_active(lpi_active), .tx_hold(tx_hold), .lpi_terminate(lpi_terminate),
    .np_codeword(np_codeword), .irq(irq));

  initial begin
    forever #2.5 sys_clk = ~sys_clk;
  end

  // ----------------------------------------------------------------
  // bus tasks
  // ----------------------------------------------------------------
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
  endtask
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // one slave, so its hreadyout is the bus ready the master waits on
  task automatic bus(input logic wr, input logic [9:0] idx, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= {20'h0, idx, 2'h0};
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wr(input logic [9:0] idx, input logic [31:0] d);
    logic [31:0] x;
    bus(1'b1, idx, d, x);
  endtask
  task automatic rc(input string nm, input logic [9:0] idx, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, idx, 32'h0, x);
    chk(nm, x, exp);
  endtask
  task automatic end_of_test;
    if (err_total == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    err_total++;
    end_of_test();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    rc("recovery", `EANP_IDX_P1_RECOVERY, 32'h27);
    rc("buf_ctrl", `EANP_IDX_BUF_LPI_CTRL, 32'h08);
    rc("np_tx", `EANP_IDX_P2_NP_TX, 32'h2001);
    rc("irq_mask", `EANP_IDX_IRQ_MASK, 32'h0);
    rc("status", `EANP_IDX_P1_STATUS, 32'h0);
    wr(`EANP_IDX_P1_RECOVERY, 32'ha5);
    rc("recovery", `EANP_IDX_P1_RECOVERY, 32'ha5);
    wr(`EANP_IDX_BUF_LPI_CTRL, 32'hff);
    rc("buf_ctrl", `EANP_IDX_BUF_LPI_CTRL, 32'hbf);
    wr(`EANP_IDX_P2_NP_TX, 32'hffff);
    rc("np_tx", `EANP_IDX_P2_NP_TX, 32'h2001);
    wr(10'h0e5, 32'hffff);
    rc("unmapped", 10'h0e5, 32'h0);
    for (n = 0; n < 4; n++) begin
      np_able <= n[1];
      an_able <= n[0];
      cyc(1);
      rc("status", `EANP_IDX_P1_STATUS, {29'h0, n[1], 1'b0, n[0]});
    end
    page_rx <= 1'b1;
    cyc(1);
    page_rx <= 1'b0;
    cyc(3);
    chk("irq", irq, 1'b0);
    wr(`EANP_IDX_IRQ_MASK, 32'h1);
    cyc(2);
    chk("irq", irq, 1'b1);
    rc("status", `EANP_IDX_P1_STATUS, 32'h7);
    rc("status", `EANP_IDX_P1_STATUS, 32'h5);
    rc("irq_st", `EANP_IDX_IRQ_STATUS, 32'h1);
    cyc(2);
    chk("irq", irq, 1'b0);
    for (n = 0; n < 2; n++) begin
      e = n[0] ? 16'h2a5a : 16'hd5a5;
      wr(`EANP_IDX_P2_NP_STAGE, {16'h0, e});
      base_tog <= n[0];
      base_load <= 1'b1;
      cyc(1);
      base_load <= 1'b0;
      cyc(2);
      e = e & 16'hb7ff;
      rc("np_tx", `EANP_IDX_P2_NP_TX, {16'h0, e | {4'h0, ~n[0], 11'h0}});
      chk("np_code", np_codeword, {16'h0, e | {4'h0, ~n[0], 11'h0}});
      page_sent <= 1'b1;
      cyc(1);
      page_sent <= 1'b0;
      cyc(2);
      rc("np_tx", `EANP_IDX_P2_NP_TX, {16'h0, e | {4'h0, n[0], 11'h0}});
    end
    t = 3'h0;
    wr(`EANP_IDX_IRQ_MASK, 32'h6);
    wr(`EANP_IDX_P1_RECOVERY, 32'h2);
    wr(`EANP_IDX_BUF_LPI_CTRL, 32'h08);
    lpi_req <= 1'b1;
    traffic <= 1'b1;
    cyc(6);
    chk("lpi_on", lpi_active, 1'b1);
    wr(`EANP_IDX_BUF_LPI_CTRL, 32'h88);
    for (n = 0; n < 50 && tx_hold !== 1'b1; n++)
      @(posedge sys_clk);
    for (n = 0; n < 300 && tx_hold === 1'b1; n++)
      @(posedge sys_clk);
    chk("hold_len", n, 256);
    chk("lpi_on", lpi_active, 1'b0);
    chk("irq", irq, 1'b1);
    traffic <= 1'b0;
    rc("irq_st", `EANP_IDX_IRQ_STATUS, 32'h4);
    usage <= {7'd0, 7'd8, 7'd0};
    cyc(4);
    chk("lpi_on", lpi_active, 1'b1);
    usage <= {7'd0, 7'd9, 7'd0};
    repeat (4) begin
      @(posedge sys_clk);
      t = t | lpi_terminate;
    end
    chk("terminate", t, 3'h2);
    chk("lpi_on", lpi_active, 1'b0);
    usage <= '0;
    cyc(2);
    rc("irq_st", `EANP_IDX_IRQ_STATUS, 32'h2);
    fiber <= 1'b1;
    cyc(300);
    chk("lpi_fiber", lpi_active, 1'b0);
    fiber <= 1'b0;
    cyc(300);
    chk("lpi_on", lpi_active, 1'b1);
    lpi_req <= 1'b0;
    cyc(3);
    chk("lpi_off", lpi_active, 1'b0);
    end_of_test();
  end
endmodule
